// ==== bench/pei_host_model.sv ====
// Host processor model: AXI4-Lite master tasks for register access.
// Assumes the testbench top provides a hang task for stalled transfers.
`timescale 1ns/1ps
module pei_host_model (
    input  wire logic                   i_clk,
    input  wire pei_pkg::pei_axi_resp_t i_rsp,
    output pei_pkg::pei_axi_req_t       o_req
);
    initial o_req = '0;

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        int n;
        @(posedge i_clk);
        o_req.awaddr  <= {idx, 2'h0};
        o_req.awvalid <= 1'b1;
        o_req.wdata   <= {24'h0, d};
        o_req.wstrb   <= 4'hf;
        o_req.wvalid  <= 1'b1;
        o_req.bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge i_clk);
            if (i_rsp.awready) o_req.awvalid <= 1'b0;
            if (i_rsp.wready) o_req.wvalid <= 1'b0;
            if (i_rsp.bvalid) break;
        end
        if (n == 50) pmic_event_irq_fault_log_tb_top.hang();
        o_req.bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, output logic [7:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge i_clk);
        o_req.araddr  <= {idx, 2'h0};
        o_req.arvalid <= 1'b1;
        o_req.rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge i_clk);
            if (i_rsp.arready) o_req.arvalid <= 1'b0;
            if (i_rsp.rvalid) break;
        end
        if (n == 50) pmic_event_irq_fault_log_tb_top.hang();
        d = i_rsp.rdata[7:0];
        r = i_rsp.rresp;
        o_req.rready <= 1'b0;
    endtask
endmodule

// ==== bench/pmic_event_irq_fault_log_tb_top.sv ====
// Self-checking bench for the event, mask and fault log block.
// Assumes the host model drives all register traffic.
`timescale 1ns/1ps
module pmic_event_irq_fault_log_tb_top;
    localparam logic [7:0] DOM_BITS = 8'h47;
    logic                   i_clk = 1'b0;
    logic                   i_resetn = 1'b0;
    pei_pkg::pei_axi_req_t  axi_req;
    pei_pkg::pei_axi_resp_t axi_rsp;
    logic [7:0]             gpi = '0;
    logic [2:0]             dom = '0;
    logic                   hit = 1'b0;
    logic                   rst_out_n = 1'b0;
    logic                   pwrup = 1'b0;
    logic                   irq_n;
    logic [23:0]            lower = '0;
    pei_pkg::pei_fault_t    flt = '0;
    int                     failures = 0;
    int                     total_checks = 0;
    int                     k;
    logic [7:0]             rd_d;
    logic [1:0]             rd_r;

    always #2.5 i_clk = ~i_clk;

    pei_top #(.UV_WINDOW_CYCLES(32'd50)) dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_axi(axi_req), .o_axi(axi_rsp),
        .i_gpi_high(gpi), .i_system_domain_request(dom[0]),
        .i_main_domain_request(dom[1]), .i_aux_domain_request(dom[2]),
        .i_fast_two_wire_port_hit(hit), .i_lower_events(lower),
        .i_fault(flt), .i_system_reset_out_n(rst_out_n),
        .i_powerup_active(pwrup), .o_interrupt_out_low(irq_n)
    );
    pei_host_model host (.i_clk(i_clk), .i_rsp(axi_rsp), .o_req(axi_req));

    function automatic logic [7:0] fault_exp(input int i);
        logic [7:0] t [7] = '{8'h01, 8'h02, 8'h08, 8'h20, 8'h20, 8'h40, 8'h80};
        return t[i];
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
        host.rd(idx, rd_d, rd_r);
        chk(rd_d, exp);
    endtask

    task automatic irq(input logic exp);
        repeat (3) @(posedge i_clk);
        chk({7'h0, irq_n}, {7'h0, exp});
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic hang();
        failures++;
        $display("unexpected at %0t: bus wait timed out", $time);
        end_of_test();
    endtask

    initial begin
        k = $urandom(62152);
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        irq(1'b1);
        rchk(pei_pkg::IDX_FAULT_LOG, 8'h02);
        for (k = 0; k < 4; k++) rchk(pei_pkg::IDX_MASK_A + 6'(k), 8'h00);
        host.rd(6'h3f, rd_d, rd_r);
        chk({6'h0, rd_r}, {6'h0, pei_pkg::RESP_SLVERR});
        k = $urandom_range(7);
        @(posedge i_clk) gpi <= 8'h01 << k;
        irq(1'b0);
        rchk(pei_pkg::IDX_EVENT_D, 8'h01 << k);
        host.wr(pei_pkg::IDX_EVENT_D, ~(8'h01 << k));
        rchk(pei_pkg::IDX_EVENT_D, 8'h01 << k);
        host.wr(pei_pkg::IDX_EVENT_D, 8'h01 << k);
        rchk(pei_pkg::IDX_EVENT_D, 8'h00);
        irq(1'b1);
        @(posedge i_clk) gpi <= 8'h00;
        dom <= 3'h7;
        hit <= 1'b1;
        @(posedge i_clk) hit <= 1'b0;
        rchk(pei_pkg::IDX_EVENT_D, DOM_BITS);
        host.wr(pei_pkg::IDX_MASK_D, 8'h07);
        irq(1'b0);
        host.wr(pei_pkg::IDX_MASK_D, DOM_BITS);
        irq(1'b1);
        for (k = 0; k < 8; k++)
            if (DOM_BITS[k]) host.wr(pei_pkg::IDX_EVENT_D, 8'h01 << k);
        rchk(pei_pkg::IDX_EVENT_D, 8'h00);
        host.wr(pei_pkg::IDX_MASK_D, 8'h00);
        irq(1'b1);
        // Regulator control inputs masked by software
        host.wr(pei_pkg::IDX_MASK_C, 8'h06);
        host.wr(pei_pkg::IDX_MASK_D, 8'h10);
        @(posedge i_clk) lower <= 24'h02_0000 << $urandom_range(1);
        gpi <= 8'h10;
        @(posedge i_clk) lower <= '0;
        irq(1'b1);
        rchk(pei_pkg::IDX_EVENT_D, 8'h10);
        host.wr(pei_pkg::IDX_EVENT_C, 8'h06);
        host.wr(pei_pkg::IDX_EVENT_D, 8'h10);
        host.wr(pei_pkg::IDX_MASK_C, 8'h00);
        host.wr(pei_pkg::IDX_MASK_D, 8'h00);
        @(posedge i_clk) gpi <= 8'h00;
        irq(1'b1);
        k = $urandom_range(23);
        @(posedge i_clk) pwrup <= 1'b1;
        lower <= 24'h1 << k;
        @(posedge i_clk) lower <= '0;
        irq(1'b1);
        @(posedge i_clk) pwrup <= 1'b0;
        irq(1'b0);
        rchk(pei_pkg::IDX_EVENT_A + 6'(k / 8), 8'h01 << (k % 8));
        host.wr(pei_pkg::IDX_EVENT_A + 6'(k / 8), 8'h01 << (k % 8));
        irq(1'b1);
        host.wr(pei_pkg::IDX_FAULT_LOG, 8'hff);
        for (k = 0; k < 7; k++) begin
            @(posedge i_clk) flt <= pei_pkg::pei_fault_t'(7'h40 >> k);
            @(posedge i_clk) flt <= '0;
            rchk(pei_pkg::IDX_FAULT_LOG, fault_exp(k));
            rchk(pei_pkg::IDX_FAULT_LOG, fault_exp(k));
            host.wr(pei_pkg::IDX_FAULT_LOG, 8'hff);
        end
        @(posedge i_clk) rst_out_n <= 1'b1;
        repeat (5) @(posedge i_clk);
        flt <= pei_pkg::pei_fault_t'(7'h20);
        @(posedge i_clk) flt <= '0;
        rchk(pei_pkg::IDX_FAULT_LOG, 8'h06);
        host.wr(pei_pkg::IDX_FAULT_LOG, 8'hff);
        // Undervoltage after the window has closed
        repeat (60) @(posedge i_clk);
        flt <= pei_pkg::pei_fault_t'(7'h20);
        @(posedge i_clk) flt <= '0;
        rchk(pei_pkg::IDX_FAULT_LOG, 8'h02);
        end_of_test();
    end
endmodule

// ==== design/pei_top.sv ====
// Event latching, interrupt masking and power-down fault log, AXI4-Lite slave.
// Assumes all inputs synchronous to i_clk and cause pulses one cycle wide.
//
// Overview of operation
// - Upper event register latches inputs 8 to 15 on reaching active state.
// - Bits 0, 1, 2 also set by system, main, aux domain requests.
// - Bit 6 also set when host addresses the fast two-wire port.
// - Writing one clears a latched bit; zero leaves it unchanged.
// - Interrupt stays asserted until every unmasked latched event is cleared.
// - Fault log bits 0, 1, 3: watchdog, rail undervoltage, overtemperature.
// - Fault bit 2 set on rail undervoltage within 10 s of reset release.
// - Fault bit 5 set on long on-key press or inputs 14, 15 held.
// - Fault bit 6 on forced-off pin, bit 7 on wait step time-out.
// - Four masks match event registers bit for bit; one blocks interrupt.
// - Upper mask bit 6 blocks input 14 and two-wire addressing events.
// - Event bit set on change to active status; unmasked event asserts interrupt low.
// - Interrupt held released during power-up sequence.
// - Event arriving during a clear is kept; set wins over clear.
`timescale 1ns/1ps
module pei_top #(
    parameter logic [31:0] UV_WINDOW_CYCLES = 32'(pei_pkg::UV_WINDOW_CYC)
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    input  wire pei_pkg::pei_axi_req_t  i_axi,
    output pei_pkg::pei_axi_resp_t      o_axi,
    input  wire logic [7:0]             i_gpi_high,
    input  wire logic                   i_system_domain_request,
    input  wire logic                   i_main_domain_request,
    input  wire logic                   i_aux_domain_request,
    input  wire logic                   i_fast_two_wire_port_hit,
    input  wire logic [23:0]            i_lower_events,
    input  wire pei_pkg::pei_fault_t    i_fault,
    input  wire logic                   i_system_reset_out_n,
    input  wire logic                   i_powerup_active,
    output logic                        o_interrupt_out_low
);

    // Register file state
    logic [7:0]  evt_a_reg, evt_b_reg, evt_c_reg, evt_d_reg;
    logic [7:0]  evt_a_next, evt_b_next, evt_c_next, evt_d_next;
    logic [7:0]  mask_a_reg, mask_b_reg, mask_c_reg, mask_d_reg;
    logic [7:0]  mask_a_next, mask_b_next, mask_c_next, mask_d_next;
    logic [7:0]  fault_reg, fault_next;
    logic [7:0]  pol_reg, pol_next;

    // Edge detection state
    logic [7:0]  act_prev_reg, act_prev_next;
    logic [2:0]  req_prev_reg, req_prev_next;
    logic [7:0]  gpi_act;
    logic [7:0]  gpi_rise;
    logic [7:0]  set_d;
    logic [2:0]  req_now;

    // Undervoltage window after reset release
    pei_pkg::pei_win_state_t win_state_reg, win_state_next;
    logic [31:0] win_cnt_reg, win_cnt_next;
    logic        rst_out_prev_reg, rst_out_prev_next;

    // Bus slave state
    logic [7:0]  awaddr_reg, awaddr_next;
    logic [7:0]  wbyte_reg, wbyte_next;
    logic        aw_held_reg, aw_held_next;
    logic        w_held_reg, w_held_next;
    pei_pkg::pei_axi_resp_t axi_reg, axi_next;
    logic        irq_low_reg, irq_low_next;

    logic        wr_en;
    logic [5:0]  widx;
    logic [5:0]  ridx;
    logic        w_mapped;
    logic [7:0]  clr_a, clr_b, clr_c, clr_d, clr_f;
    logic [7:0]  rbyte;
    logic        r_mapped;
    logic        pending;

    assign o_axi               = axi_reg;
    assign o_interrupt_out_low = irq_low_reg;

    // Active level per input, polarity one means active high
    assign gpi_act = ~(i_gpi_high ^ pol_reg);
    assign gpi_rise = gpi_act & ~act_prev_reg;
    assign req_now = {i_aux_domain_request, i_main_domain_request,
                      i_system_domain_request};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_set_d
            if (gi <= pei_pkg::BIT_AUX_REQ) begin : g_req
                assign set_d[gi] = gpi_rise[gi] |
                                   (req_now[gi] & ~req_prev_reg[gi]);
            end else if (gi == pei_pkg::BIT_TWO_WIRE) begin : g_tw
                assign set_d[gi] = gpi_rise[gi] | i_fast_two_wire_port_hit;
            end else begin : g_gpi
                assign set_d[gi] = gpi_rise[gi];
            end
        end
    endgenerate

    // Write decode: applied once both address and data are held
    assign wr_en = aw_held_reg & w_held_reg;
    assign widx  = awaddr_reg[7:2];

    always_comb begin
        clr_a    = 8'h00;
        clr_b    = 8'h00;
        clr_c    = 8'h00;
        clr_d    = 8'h00;
        clr_f    = 8'h00;
        w_mapped = 1'b1;
        if (widx == pei_pkg::IDX_EVENT_A) begin
            clr_a = wbyte_reg;
        end else if (widx == pei_pkg::IDX_EVENT_B) begin
            clr_b = wbyte_reg;
        end else if (widx == pei_pkg::IDX_EVENT_C) begin
            clr_c = wbyte_reg;
        end else if (widx == pei_pkg::IDX_EVENT_D) begin
            clr_d = wbyte_reg;
        end else if (widx == pei_pkg::IDX_FAULT_LOG) begin
            clr_f = wbyte_reg;
        end else if (widx == pei_pkg::IDX_MASK_A ||
                     widx == pei_pkg::IDX_MASK_B ||
                     widx == pei_pkg::IDX_MASK_C ||
                     widx == pei_pkg::IDX_MASK_D ||
                     widx == pei_pkg::IDX_POLARITY) begin
            w_mapped = 1'b1;
        end else begin
            w_mapped = 1'b0;
        end
        if (!wr_en) begin
            clr_a = 8'h00;
            clr_b = 8'h00;
            clr_c = 8'h00;
            clr_d = 8'h00;
            clr_f = 8'h00;
        end
    end

    // Read decode
    assign ridx = i_axi.araddr[7:2];

    always_comb begin
        rbyte    = 8'h00;
        r_mapped = 1'b1;
        if (ridx == pei_pkg::IDX_EVENT_A) begin
            rbyte = evt_a_reg;
        end else if (ridx == pei_pkg::IDX_EVENT_B) begin
            rbyte = evt_b_reg;
        end else if (ridx == pei_pkg::IDX_EVENT_C) begin
            rbyte = evt_c_reg;
        end else if (ridx == pei_pkg::IDX_EVENT_D) begin
            rbyte = evt_d_reg;
        end else if (ridx == pei_pkg::IDX_FAULT_LOG) begin
            rbyte = fault_reg;
        end else if (ridx == pei_pkg::IDX_MASK_A) begin
            rbyte = mask_a_reg;
        end else if (ridx == pei_pkg::IDX_MASK_B) begin
            rbyte = mask_b_reg;
        end else if (ridx == pei_pkg::IDX_MASK_C) begin
            rbyte = mask_c_reg;
        end else if (ridx == pei_pkg::IDX_MASK_D) begin
            rbyte = mask_d_reg;
        end else if (ridx == pei_pkg::IDX_POLARITY) begin
            rbyte = pol_reg;
        end else begin
            r_mapped = 1'b0;
        end
    end

    // Event, mask and fault next values
    always_comb begin
        evt_a_next = (evt_a_reg & ~clr_a) | i_lower_events[7:0];
        evt_b_next = (evt_b_reg & ~clr_b) | i_lower_events[15:8];
        evt_c_next = (evt_c_reg & ~clr_c) | i_lower_events[23:16];
        evt_d_next = (evt_d_reg & ~clr_d) | set_d;
        act_prev_next = gpi_act;
        req_prev_next = req_now;

        mask_a_next = mask_a_reg;
        mask_b_next = mask_b_reg;
        mask_c_next = mask_c_reg;
        mask_d_next = mask_d_reg;
        pol_next    = pol_reg;
        if (wr_en && widx == pei_pkg::IDX_MASK_A) begin
            mask_a_next = wbyte_reg;
        end else if (wr_en && widx == pei_pkg::IDX_MASK_B) begin
            mask_b_next = wbyte_reg;
        end else if (wr_en && widx == pei_pkg::IDX_MASK_C) begin
            mask_c_next = wbyte_reg;
        end else if (wr_en && widx == pei_pkg::IDX_MASK_D) begin
            mask_d_next = wbyte_reg;
        end else if (wr_en && widx == pei_pkg::IDX_POLARITY) begin
            pol_next = wbyte_reg;
        end

        // only causes and one-writes touch the log
        fault_next = fault_reg & ~clr_f;
        fault_next[pei_pkg::FLT_WATCHDOG] = fault_next[pei_pkg::FLT_WATCHDOG] |
                                            i_fault.watchdog;
        fault_next[pei_pkg::FLT_RAIL_UV]  = fault_next[pei_pkg::FLT_RAIL_UV] |
                                            i_fault.rail_uv;
        fault_next[pei_pkg::FLT_OVERTEMP] = fault_next[pei_pkg::FLT_OVERTEMP] |
                                            i_fault.overtemp;
        fault_next[pei_pkg::FLT_UV_EARLY] = fault_next[pei_pkg::FLT_UV_EARLY] |
            (i_fault.rail_uv & (win_state_reg == pei_pkg::WIN_OPEN));
        fault_next[pei_pkg::FLT_KEY] = fault_next[pei_pkg::FLT_KEY] |
            i_fault.key_long | i_fault.gpi_pair_hold;
        fault_next[pei_pkg::FLT_FORCED] = fault_next[pei_pkg::FLT_FORCED] |
                                          i_fault.forced_off;
        fault_next[pei_pkg::FLT_WAIT]   = fault_next[pei_pkg::FLT_WAIT] |
                                          i_fault.wait_timeout;
    end

    // window opens on reset release, closes after the count
    always_comb begin
        win_state_next    = win_state_reg;
        win_cnt_next      = win_cnt_reg;
        rst_out_prev_next = i_system_reset_out_n;
        case (win_state_reg)
            pei_pkg::WIN_CLOSED: begin
                if (i_system_reset_out_n && !rst_out_prev_reg) begin
                    win_state_next = pei_pkg::WIN_OPEN;
                    win_cnt_next   = 32'h0000_0000;
                end
            end
            pei_pkg::WIN_OPEN: begin
                win_cnt_next = win_cnt_reg + 32'h0000_0001;
                if (!i_system_reset_out_n ||
                    win_cnt_reg >= UV_WINDOW_CYCLES - 32'h0000_0001) begin
                    win_state_next = pei_pkg::WIN_CLOSED;
                end
            end
            default: begin
                win_state_next = pei_pkg::WIN_CLOSED;
            end
        endcase
    end

    // masks gate events, one mask bit covers both sources
    assign pending = |(evt_a_reg & ~mask_a_reg) | |(evt_b_reg & ~mask_b_reg) |
                     |(evt_c_reg & ~mask_c_reg) | |(evt_d_reg & ~mask_d_reg);

    always_comb begin
        // released during power-up, low while any pending
        irq_low_next = i_powerup_active ? 1'b1 : ~pending;
    end

    // AXI4-Lite slave
    always_comb begin
        awaddr_next  = awaddr_reg;
        wbyte_next   = wbyte_reg;
        aw_held_next = aw_held_reg;
        w_held_next  = w_held_reg;
        axi_next     = axi_reg;
        if (i_axi.awvalid && axi_reg.awready) begin
            awaddr_next  = i_axi.awaddr;
            aw_held_next = 1'b1;
        end
        if (i_axi.wvalid && axi_reg.wready) begin
            wbyte_next  = i_axi.wstrb[0] ? i_axi.wdata[7:0] : 8'h00;
            w_held_next = 1'b1;
        end
        if (wr_en) begin
            aw_held_next   = 1'b0;
            w_held_next    = 1'b0;
            axi_next.bvalid = 1'b1;
            axi_next.bresp  = w_mapped ? pei_pkg::RESP_OKAY
                                       : pei_pkg::RESP_SLVERR;
        end else if (axi_reg.bvalid && i_axi.bready) begin
            axi_next.bvalid = 1'b0;
        end
        axi_next.awready = ~aw_held_next & ~axi_next.bvalid;
        axi_next.wready  = ~w_held_next & ~axi_next.bvalid;

        if (i_axi.arvalid && axi_reg.arready) begin
            axi_next.rvalid = 1'b1;
            axi_next.rdata  = {24'h00_0000, rbyte};
            axi_next.rresp  = r_mapped ? pei_pkg::RESP_OKAY
                                       : pei_pkg::RESP_SLVERR;
        end else if (axi_reg.rvalid && i_axi.rready) begin
            axi_next.rvalid = 1'b0;
        end
        axi_next.arready = ~axi_next.rvalid;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            evt_a_reg        <= pei_pkg::EVENT_RST;
            evt_b_reg        <= pei_pkg::EVENT_RST;
            evt_c_reg        <= pei_pkg::EVENT_RST;
            evt_d_reg        <= pei_pkg::EVENT_RST;
            mask_a_reg       <= pei_pkg::MASK_RST;
            mask_b_reg       <= pei_pkg::MASK_RST;
            mask_c_reg       <= pei_pkg::MASK_RST;
            mask_d_reg       <= pei_pkg::MASK_RST;
            fault_reg        <= pei_pkg::FAULT_RST;
            pol_reg          <= pei_pkg::POLARITY_RST;
            act_prev_reg     <= pei_pkg::ACT_PREV_RST;
            req_prev_reg     <= 3'h7;
            win_state_reg    <= pei_pkg::WIN_CLOSED;
            win_cnt_reg      <= 32'h0000_0000;
            rst_out_prev_reg <= 1'b1;
            awaddr_reg       <= 8'h00;
            wbyte_reg        <= 8'h00;
            aw_held_reg      <= 1'b0;
            w_held_reg       <= 1'b0;
            axi_reg          <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                  default: '0};
            irq_low_reg      <= 1'b1;
        end else begin
            evt_a_reg        <= evt_a_next;
            evt_b_reg        <= evt_b_next;
            evt_c_reg        <= evt_c_next;
            evt_d_reg        <= evt_d_next;
            mask_a_reg       <= mask_a_next;
            mask_b_reg       <= mask_b_next;
            mask_c_reg       <= mask_c_next;
            mask_d_reg       <= mask_d_next;
            fault_reg        <= fault_next;
            pol_reg          <= pol_next;
            act_prev_reg     <= act_prev_next;
            req_prev_reg     <= req_prev_next;
            win_state_reg    <= win_state_next;
            win_cnt_reg      <= win_cnt_next;
            rst_out_prev_reg <= rst_out_prev_next;
            awaddr_reg       <= awaddr_next;
            wbyte_reg        <= wbyte_next;
            aw_held_reg      <= aw_held_next;
            w_held_reg       <= w_held_next;
            axi_reg          <= axi_next;
            irq_low_reg      <= irq_low_next;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    AST_GPI_EDGE: assert property (
        gpi_rise[7] |=> evt_d_reg[7]) else $error("input 7 event missed");
    AST_SYS_REQ: assert property (
        (i_system_domain_request && !req_prev_reg[0]) |=> evt_d_reg[0])
        else $error("system request event missed");
    AST_TWO_WIRE: assert property (
        i_fast_two_wire_port_hit |=> evt_d_reg[6])
        else $error("two-wire event missed");
    AST_ZERO_KEEPS: assert property (
        (wr_en && widx == pei_pkg::IDX_EVENT_D && !wbyte_reg[5] &&
         evt_d_reg[5]) |=> evt_d_reg[5]) else $error("zero write cleared");
    AST_ONE_CLEARS: assert property (
        (wr_en && widx == pei_pkg::IDX_EVENT_D && wbyte_reg[4] &&
         !set_d[4]) |=> !evt_d_reg[4]) else $error("one write kept bit");
    AST_IRQ_HOLD: assert property (
        (pending && !i_powerup_active) |=> !o_interrupt_out_low)
        else $error("interrupt not asserted");
    AST_IRQ_FREE: assert property (
        (!pending && !i_powerup_active) |=> o_interrupt_out_low)
        else $error("interrupt not released");
    AST_MASK14: assert property (
        (mask_d_reg[6] && evt_d_reg == 8'h40 && evt_a_reg == 8'h00 &&
         evt_b_reg == 8'h00 && evt_c_reg == 8'h00) |-> !pending)
        else $error("masked bit 6 still pending");
    AST_POWERUP: assert property (
        i_powerup_active |=> o_interrupt_out_low)
        else $error("interrupt during power-up");
    AST_SET_WINS: assert property (
        (wr_en && widx == pei_pkg::IDX_EVENT_D && i_fast_two_wire_port_hit)
        |=> evt_d_reg[6]) else $error("event lost during clear");
    AST_WATCHDOG: assert property (
        i_fault.watchdog |=> fault_reg[0]) else $error("watchdog not logged");
    AST_UV_EARLY: assert property (
        (i_fault.rail_uv && win_state_reg == pei_pkg::WIN_OPEN)
        |=> fault_reg[2] && fault_reg[1]) else $error("early uv not logged");
    AST_FAULT_KEEP: assert property (
        (fault_reg & ~$past(fault_reg)) != 8'h00 |-> $past(i_fault) != '0)
        else $error("fault log set by itself");
    AST_FAULT_CLR: assert property (
        ($past(fault_reg) & ~fault_reg) != 8'h00 |->
        $past(wr_en) && $past(widx) == pei_pkg::IDX_FAULT_LOG)
        else $error("fault log cleared by itself");
    AST_BRESP: assert property (
        wr_en |=> axi_reg.bvalid ##0 !axi_reg.awready)
        else $error("no write response");

endmodule

// ==== inc/pei_pkg.sv ====
// Package for the power event latch, interrupt mask and fault log block.
// Assumes a 200 MHz system clock and an AXI4-Lite master with 8-bit addresses.
package pei_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_EVENT_A   = 6'h05;
    localparam logic [5:0] IDX_EVENT_B   = 6'h06;
    localparam logic [5:0] IDX_EVENT_C   = 6'h07;
    localparam logic [5:0] IDX_EVENT_D   = 6'h08;
    localparam logic [5:0] IDX_FAULT_LOG = 6'h09;
    localparam logic [5:0] IDX_MASK_A    = 6'h0a;
    localparam logic [5:0] IDX_MASK_B    = 6'h0b;
    localparam logic [5:0] IDX_MASK_C    = 6'h0c;
    localparam logic [5:0] IDX_MASK_D    = 6'h0d;
    localparam logic [5:0] IDX_POLARITY  = 6'h10;

    // Reset values
    localparam logic [7:0] EVENT_RST     = 8'h00;
    localparam logic [7:0] MASK_RST      = 8'h00;
    localparam logic [7:0] FAULT_RST     = 8'h02;
    localparam logic [7:0] POLARITY_RST  = 8'hff;
    localparam logic [7:0] ACT_PREV_RST  = 8'hff;

    // Upper event register bit positions
    localparam int unsigned BIT_SYS_REQ  = 0;
    localparam int unsigned BIT_MAIN_REQ = 1;
    localparam int unsigned BIT_AUX_REQ  = 2;
    localparam int unsigned BIT_TWO_WIRE = 6;

    // Fault log bit positions
    localparam int unsigned FLT_WATCHDOG = 0;
    localparam int unsigned FLT_RAIL_UV  = 1;
    localparam int unsigned FLT_UV_EARLY = 2;
    localparam int unsigned FLT_OVERTEMP = 3;
    localparam int unsigned FLT_KEY      = 5;
    localparam int unsigned FLT_FORCED   = 6;
    localparam int unsigned FLT_WAIT     = 7;

    // Timing
    localparam longint unsigned CLK_HZ        = 64'd200_000_000;
    localparam longint unsigned UV_WINDOW_S   = 64'd10;
    localparam longint unsigned UV_WINDOW_CYC = UV_WINDOW_S * CLK_HZ;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } pei_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pei_axi_resp_t;

    // Power-down causes, each a one-cycle pulse from the sequencer
    typedef struct packed {
        logic watchdog;
        logic rail_uv;
        logic overtemp;
        logic key_long;
        logic gpi_pair_hold;
        logic forced_off;
        logic wait_timeout;
    } pei_fault_t;

    typedef enum logic [0:0] {
        WIN_CLOSED = 1'b0,
        WIN_OPEN   = 1'b1
    } pei_win_state_t;

endpackage
